//--- design/dai_consts.svh
// Constants for the channel auto-reload control block
`ifndef DAI_CONSTS_SVH
`define DAI_CONSTS_SVH
`define DAI_ADDR_CTRL 4'h0
`define DAI_ADDR_STAT 4'h1
`define DAI_ADDR_CFG 4'h2
`define DAI_ADDR_WORK 4'h3
`define DAI_BIT_AUTO 8
`define DAI_BIT_REPEAT 9
`define DAI_BIT_EOP 11
`define DAI_BIT_EN 15
`define DAI_CTRL_RESET 16'h0000
`define DAI_CTRL_MASK 16'h0b00
`define DAI_CFG_RESET 16'h0000
`endif

//--- design/dai_pkg.sv
// Types shared by the auto-reload control block
package dai_pkg;
  typedef enum logic [1:0] {DAI_IDLE, DAI_RUN, DAI_WAIT} dai_state_type;
endpackage

//--- design/dai_copy_if.sv
// Interface carrying the configuration-to-working copy
`timescale 1ns/1ps
interface dai_copy_if #(parameter int WIDTH = 16);
  logic load; // Copy strobe
  logic [WIDTH-1:0] cfg; // Configuration value
  logic [WIDTH-1:0] work; // Working value
  modport ctl (output load, output cfg, input work);
  modport store (input load, input cfg, output work);
endinterface

//--- design/dai_work_store.sv
// Working register set, loaded only by the copy strobe
`timescale 1ns/1ps
module dai_work_store
  import dai_pkg::*;
(
  input wire clk, // System clock
  input wire sys_rst, // Async reset, active high
  dai_copy_if.store cp // Copy port
);
  logic [$bits(cp.work)-1:0] work_r; // Working copy

  // Load only on copy; config writes alone never reach here
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      work_r <= '0;
    end
    else if (cp.load)
    begin
      work_r <= cp.cfg;
    end
  end

  assign cp.work = work_r;
endmodule // dai_work_store

//--- design/dai_auto_reload_enable_ctrl.sv
// Channel auto-reload control: control register, copy and restart
// Notes on behaviour
// - Block end clears active unless reloading
// - Auto mode: copy config, then re-enable
// - Bit 8 enables auto reload
// - Bit 9 selects handshake or free reload
// - Hardware clears bit 11 after a block-end copy; a start copy keeps it
// - Bit 11: 0 free, 1 programmed
// - Config writes never touch working set
// - Bits 11, 9, 8 reset to zero, RW
// - Repeat 1 ignores flag; 0 waits
// - Auto off or cleared: stop at end
// - Enable cleared stops channel at once
// - Setting enable also copies config
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "dai_consts.svh"
module dai_auto_reload_enable_ctrl
  import dai_pkg::*;
#(
  parameter int WIDTH = 16 // Width of the modelled context word
)
(
  input wire clk, // System clock
  input wire sys_rst, // Async reset, active high
  input wire [3:0] regAddr, // Register index
  input wire [15:0] regWdata, // Write data
  input wire regWr, // Write strobe
  input wire regRd, // Read strobe
  output logic [15:0] regRdata, // Read data, cycle after strobe
  input wire blockDone, // Last element of block moved
  output logic chanActive, // Channel running a block
  output logic copyPulse, // Config copied to working set
  output logic [WIDTH-1:0] workCtx // Working context word
);
  dai_copy_if #(.WIDTH(WIDTH)) cp (); // Copy link to store

  logic autoReload_r; // Auto reload enable
  logic repeatSel_r; // Reload without handshake
  logic end_of_programming_flag_r; // End-of-programming flag
  logic chanEn_r; // Channel enable
  logic [WIDTH-1:0] cfg_r; // Configuration context
  logic [15:0] rdata_r; // Read data register
  logic [WIDTH-1:0] work_r; // Registered working copy out
  dai_state_type state_r; // Channel state
  logic wrCtrl; // Control register write
  logic wrCfg; // Config register write
  logic enRise; // Software sets enable
  logic reloadGo; // End-of-block reload taken now
  logic doCopy; // Copy this cycle
  logic [15:0] ctrlView; // Control register as read
  logic [15:0] statView; // Status word as read

  assign wrCtrl = regWr && (regAddr == `DAI_ADDR_CTRL);
  assign wrCfg = regWr && (regAddr == `DAI_ADDR_CFG);
  // Start only from a stopped channel; a parked one needs the flag
  assign enRise = wrCtrl && regWdata[`DAI_BIT_EN]
    && (state_r == DAI_IDLE);

  // Reload decision: repeat ignores flag, else flag must be 1
  always_comb
  begin
    reloadGo = 1'b0;
    case (state_r)
      DAI_RUN:
      begin
        // Flag already set reloads in the same cycle
        reloadGo = blockDone && autoReload_r &&
          (repeatSel_r || end_of_programming_flag_r);
      end
      DAI_WAIT:
      begin
        // Parked: only the flag releases the reload
        reloadGo = autoReload_r && end_of_programming_flag_r;
      end
      default:
      begin
        reloadGo = 1'b0;
      end
    endcase
  end

  // Start copy, or block-end copy while still enabled
  assign doCopy = enRise || (reloadGo && chanEn_r);

  // Mode bits change only by a software write
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      autoReload_r <= 1'b0;
      repeatSel_r <= 1'b0;
    end
    else if (wrCtrl)
    begin
      autoReload_r <= regWdata[`DAI_BIT_AUTO];
      repeatSel_r <= regWdata[`DAI_BIT_REPEAT];
    end
  end

  // Channel enable; hardware drops it once no reload can follow
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      chanEn_r <= 1'b0; // Stopped after reset
    end
    else if (wrCtrl)
    begin
      chanEn_r <= regWdata[`DAI_BIT_EN]; // Software write wins
    end
    else if (state_r == DAI_RUN && blockDone && !reloadGo
      && !(autoReload_r && chanEn_r))
    begin
      chanEn_r <= 1'b0;
    end
    else if (state_r == DAI_WAIT && !autoReload_r)
    begin
      // Auto cleared while parked: the reload will never come
      chanEn_r <= 1'b0;
    end
  end

  // End-of-programming flag; a core write of 1 beats the hardware clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      end_of_programming_flag_r <= 1'b0;
    end
    else if (wrCtrl && regWdata[`DAI_BIT_EOP])
    begin
      end_of_programming_flag_r <= 1'b1;
    end
    else if (doCopy && state_r != DAI_IDLE)
    begin
      // Only a block-end copy frees the set; a start copy keeps it
      end_of_programming_flag_r <= 1'b0;
    end
    else if (wrCtrl)
    begin
      end_of_programming_flag_r <= 1'b0;
    end
  end

  // Configuration context; only the copy moves it onward
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_r <= WIDTH'(`DAI_CFG_RESET);
    end
    // A write during a block waits for the next copy
    else if (wrCfg)
    begin
      cfg_r <= regWdata[WIDTH-1:0];
    end
  end

  // Channel state machine
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= DAI_IDLE;
    end
    // Clearing enable beats every state, even mid block
    else if (wrCtrl && !regWdata[`DAI_BIT_EN])
    begin
      state_r <= DAI_IDLE;
    end
    else
    begin
      case (state_r)
        // Stopped: only a software enable starts a block
        DAI_IDLE:
        begin
          if (enRise)
          begin
            state_r <= DAI_RUN;
          end
        end
        // Running: block end reloads, parks or stops
        DAI_RUN:
        begin
          if (blockDone && !reloadGo)
          begin
            // Handshake pending waits, otherwise the channel stops
            state_r <= (autoReload_r && !repeatSel_r)
              ? DAI_WAIT : DAI_IDLE;
          end
        end
        // Parked: waits for the flag, or for auto to be cleared
        DAI_WAIT:
        begin
          if (!autoReload_r)
          begin
            state_r <= DAI_IDLE;
          end
          else if (reloadGo)
          begin
            state_r <= DAI_RUN;
          end
        end
        // Unused encoding falls back to stopped
        default:
        begin
          state_r <= DAI_IDLE;
        end
      endcase
    end
  end

  // Register read view; reserved bits are constant zero
  always_comb
  begin
    // Enable is write-only here; status shows whether the channel runs
    ctrlView = 16'h0000;
    ctrlView[`DAI_BIT_AUTO] = autoReload_r;
    ctrlView[`DAI_BIT_REPEAT] = repeatSel_r;
    ctrlView[`DAI_BIT_EOP] = end_of_programming_flag_r;
    ctrlView = ctrlView & 16'(`DAI_CTRL_MASK);
  end

  // Status view: bit 0 busy, bit 1 parked on the handshake
  always_comb
  begin
    statView = 16'h0000;
    statView[0] = (state_r != DAI_IDLE); // Running or parked
    statView[1] = (state_r == DAI_WAIT); // Waiting for the flag
  end

  // Read data stands one cycle after the strobe, then drops to zero
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_r <= 16'h0000;
    end
    else if (regRd)
    begin
      case (regAddr)
        `DAI_ADDR_CTRL:
        begin
          rdata_r <= ctrlView; // Mode bits and flag
        end
        `DAI_ADDR_STAT:
        begin
          rdata_r <= statView; // Channel state
        end
        `DAI_ADDR_CFG:
        begin
          rdata_r <= 16'(cfg_r); // Next context
        end
        `DAI_ADDR_WORK:
        begin
          rdata_r <= 16'(cp.work); // Context in use
        end
        default:
        begin
          rdata_r <= 16'h0000; // Unmapped reads as zero
        end
      endcase
    end
    else
    begin
      // Zero between reads keeps stale data off the bus
      rdata_r <= 16'h0000;
    end
  end

  // Copy strobe registered as status pulse, working copy flopped
  // The extra flop keeps workCtx registered; it lags the store a cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      copyPulse <= 1'b0;
      work_r <= '0;
    end
    else
    begin
      copyPulse <= doCopy;
      work_r <= cp.work;
    end
  end

  // Copy link and output views
  assign cp.load = doCopy;
  assign cp.cfg = cfg_r;
  assign regRdata = rdata_r;
  assign chanActive = (state_r == DAI_RUN);
  assign workCtx = work_r;

  // Working set in its own store, fed only by the copy strobe
  dai_work_store u_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .cp(cp)
  );
endmodule // dai_auto_reload_enable_ctrl

//--- test/dai_auto_reload_enable_ctrl_sva.sv
// Checker for the channel auto-reload control ports
`timescale 1ns/1ps
module dai_auto_reload_enable_ctrl_sva
  import dai_pkg::*;
#(
  parameter int WIDTH = 16 // Context width
)
(
  input wire clk, // Clock
  input wire sys_rst, // Reset
  input wire [3:0] regAddr, // Index
  input wire [15:0] regWdata, // Write data
  input wire regWr, // Write strobe
  input wire regRd, // Read strobe
  input wire [15:0] regRdata, // Read data
  input wire blockDone, // Block end
  input wire chanActive, // Running
  input wire copyPulse, // Copy seen
  input wire [WIDTH-1:0] workCtx // Working word
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Control write decode
  wire ctlWr = regWr && regAddr == 4'h0;
  // Mirror of repeat and auto bits; hardware never alters them
  logic [1:0] mode_r;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      mode_r <= 2'h0;
    else if (ctlWr)
      mode_r <= regWdata[9:8];
  // A handshake-mode block end that did not restart parks the channel
  logic prevEnd_r; // Block end seen with auto on, repeat off
  logic parked_r; // Channel waiting for the flag
  wire parked = parked_r || (prevEnd_r && !chanActive);
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prevEnd_r <= 1'b0;
      parked_r <= 1'b0;
    end
    else
    begin
      prevEnd_r <= blockDone && chanActive && mode_r == 2'h1
        && !(ctlWr && !regWdata[15]);
      if ((ctlWr && !regWdata[15]) || chanActive || !mode_r[0])
        parked_r <= 1'b0;
      else if (parked)
        parked_r <= 1'b1;
    end
  end
  chk_stop_end: assert property (
    blockDone && chanActive && !mode_r[0] |=> !chanActive)
    else $error("channel ran past block end");
  chk_free_reload: assert property (
    blockDone && chanActive && mode_r == 2'h3 |=> copyPulse && chanActive)
    else $error("free reload missing");
  chk_copy_runs: assert property (
    copyPulse |-> chanActive) else $error("copy without restart");
  chk_start_copy: assert property (
    $rose(chanActive) |-> copyPulse) else $error("start without copy");
  chk_work_hold: assert property (
    !$past(copyPulse) |-> $stable(workCtx)) else $error("working set moved");
  chk_stop_now: assert property (
    ctlWr && !regWdata[15] |=> !chanActive) else $error("no prompt stop");
  chk_enable_copy: assert property (
    ctlWr && regWdata[15] && !regWdata[11] && !chanActive && !parked
    |=> copyPulse)
    else $error("enable did not copy");
  chk_rsvd_zero: assert property (
    $past(regRd) && $past(regAddr) == 4'h0 |-> (regRdata & 16'hf4ff) == 0)
    else $error("reserved bits set");
endmodule // dai_auto_reload_enable_ctrl_sva
bind dai_auto_reload_enable_ctrl dai_auto_reload_enable_ctrl_sva #(.WIDTH(WIDTH)) chk (
  .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .blockDone(blockDone), .chanActive(chanActive),
  .copyPulse(copyPulse), .workCtx(workCtx));

//--- test/test_dai_auto_reload_enable_ctrl.sv
// Self-checking bench for the auto-reload control block
`timescale 1ns/1ps
module test_dai_auto_reload_enable_ctrl;
  import dai_pkg::*;
  logic clk = 1'b0; // 10 MHz clock
  logic sys_rst = 1'b1; // Reset
  logic [3:0] regAddr = 4'h0; // Index
  logic [15:0] regWdata = 16'h0000; // Write data
  logic regWr = 1'b0; // Write strobe
  logic regRd = 1'b0; // Read strobe
  logic blockDone = 1'b0; // Block end
  logic [15:0] regRdata; // Read data
  logic chanActive; // Running
  logic copyPulse; // Copy seen
  logic [15:0] workCtx; // Working word
  int nFail = 0; // Mismatches
  int numChecks = 0; // Comparisons
  always #50 clk = ~clk;
  dai_auto_reload_enable_ctrl uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .blockDone(blockDone), .chanActive(chanActive), .copyPulse(copyPulse),
    .workCtx(workCtx));
  // Compare, count, report at once
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    numChecks++;
    if (s !== e)
    begin
      nFail++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // One-cycle write; #1 lets the edge's updates land
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask
  // Read strobe, data checked in the cycle after
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask
  // Block end pulse
  task automatic done();
    @(posedge clk);
    blockDone <= 1'b1;
    @(posedge clk);
    blockDone <= 1'b0;
    #1;
  endtask
  // Let one more edge settle
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d fails %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog; tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    nFail++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h0, 16'h0000);
    wr(4'h0, 16'h7fff);
    rd(4'h0, 16'h0b00);
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    $display("registers done");
    wr(4'h2, 16'h1234);
    wr(4'h0, 16'h8000);
    chk(16'(copyPulse), 16'h0001);
    cyc();
    chk(workCtx, 16'h1234);
    wr(4'h2, 16'h5678);
    rd(4'h3, 16'h1234);
    done();
    chk(16'(chanActive), 16'h0000);
    $display("single block done");
    wr(4'h0, 16'h8300);
    wr(4'h2, 16'h9abc);
    done();
    cyc();
    chk(workCtx, 16'h9abc);
    wr(4'h0, 16'h8000);
    chk(16'(chanActive), 16'h0001);
    done();
    chk(16'(chanActive), 16'h0000);
    $display("free reload done");
    wr(4'h0, 16'h8100);
    wr(4'h2, 16'h0f0f);
    done();
    chk(16'(chanActive), 16'h0000);
    rd(4'h0, 16'h0100);
    rd(4'h1, 16'h0003);
    wr(4'h0, 16'h8100);
    chk(16'(copyPulse), 16'h0000);
    chk(16'(chanActive), 16'h0000);
    rd(4'h3, 16'h9abc);
    wr(4'h0, 16'h8900);
    cyc();
    chk(16'(chanActive), 16'h0001);
    cyc();
    chk(workCtx, 16'h0f0f);
    rd(4'h1, 16'h0001);
    rd(4'h0, 16'h0100);
    $display("handshake done");
    wr(4'h0, 16'h8900);
    done();
    chk(16'(copyPulse), 16'h0001);
    chk(16'(chanActive), 16'h0001);
    rd(4'h0, 16'h0100);
    wr(4'h0, 16'h0100);
    chk(16'(chanActive), 16'h0000);
    $display("flag and stop done");
    wr(4'h0, 16'h8100);
    done();
    wr(4'h0, 16'h8000);
    wr(4'h0, 16'h8000);
    chk(16'(chanActive), 16'h0001);
    chk(16'(copyPulse), 16'h0001);
    wr(4'h0, 16'h0000);
    chk(16'(chanActive), 16'h0000);
    $display("park and restart done");
    complete_run();
  end
endmodule // test_dai_auto_reload_enable_ctrl
